// File: pmrb_pkg.sv
// constants, masks and types of the management register bank
// assumes a 16-bit clause-22 register set reached over the serial port
// Overview of operation
// - registers reached by index over serial port
// - indices 0..6 are the standard registers
// - vendor indices 17,18,26,27,29,30,31 decoded
// - read-only bits ignore writes, return value
// - write-only bits read back unspecified
// - write one clears, write zero keeps
// - any write clears, read shows value
// - read-to-clear registers clear after read
// - latch-low holds low until register read
// - latch-high holds until read, then condition
// - latch-high cleared by reading its register
// - self-clearing bit drops when action done
// - self-setting bit returns to one itself
// - kept bits survive software reset
// - reserved bits written zero, read undefined
// - read/write bits store and read back
// - every register sixteen bits, one word
package pmrb_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned IDX_W  = 5;

	// register indices
	localparam logic [4:0] IDX_BASIC_CONTROL   = 5'h00;
	localparam logic [4:0] IDX_BASIC_STATUS    = 5'h01;
	localparam logic [4:0] IDX_ID_HIGH         = 5'h02;
	localparam logic [4:0] IDX_ID_LOW          = 5'h03;
	localparam logic [4:0] IDX_AN_ADVERT       = 5'h04;
	localparam logic [4:0] IDX_AN_PARTNER      = 5'h05;
	localparam logic [4:0] IDX_AN_EXPANSION    = 5'h06;
	localparam logic [4:0] IDX_MODE_CTRL       = 5'h11;
	localparam logic [4:0] IDX_SPECIAL_MODES   = 5'h12;
	localparam logic [4:0] IDX_SYMBOL_ERRORS   = 5'h1a;
	localparam logic [4:0] IDX_CS_INDICATION   = 5'h1b;
	localparam logic [4:0] IDX_INT_SOURCE      = 5'h1d;
	localparam logic [4:0] IDX_INT_MASK        = 5'h1e;
	localparam logic [4:0] IDX_SPECIAL_CTRL    = 5'h1f;

	// frame layout
	localparam int unsigned PREAMBLE_LEN = 32;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [4:0] HDR_LAST      = 5'h0b;
	localparam logic [4:0] TA_LAST       = 5'h01;
	localparam logic [4:0] DATA_LAST     = 5'h0f;
	localparam logic [4:0] RD_TA_FALL    = 5'h01;
	localparam logic [4:0] RD_DATA_FALL  = 5'h02;
	localparam logic [4:0] RD_REL_FALL   = 5'h12;

	// basic control
	localparam logic [15:0] BC_RW          = 16'h7d00;
	localparam logic [15:0] BC_DROP        = 16'h8200;
	localparam logic [15:0] BC_SOFT_RESET  = 16'h8000;
	localparam logic [15:0] BC_RESTART_AN  = 16'h0200;
	localparam logic [15:0] BC_RST_DEFAULT = 16'h3100;

	// basic status
	localparam logic [15:0] BS_RST    = 16'h7809;
	localparam logic [15:0] BS_LIVE   = 16'h0020;
	localparam logic [15:0] BS_STICKY = 16'h0012;
	localparam logic [15:0] BS_LOWLAT = 16'h0004;

	// plain read/write registers
	localparam logic [15:0] ALL_BITS     = 16'hffff;
	localparam logic [15:0] ZERO_BITS    = 16'h0000;
	localparam logic [15:0] ADVERT_RST   = 16'h0000;
	localparam logic [15:0] SPMODE_RST   = 16'h0000;

	// control/status indication
	localparam logic [15:0] CSI_RW  = 16'hff00;
	localparam logic [15:0] CSI_W1C = 16'h0001;

	// special control/status
	localparam logic [15:0] SPC_RW     = 16'h20ff;
	localparam logic [15:0] SPC_ANYCLR = 16'h8000;
	localparam logic [15:0] SPC_SS     = 16'h4000;
	localparam logic [15:0] SPC_WO     = 16'h2000;
	localparam logic [15:0] SPC_RST    = 16'h4000;

	typedef enum logic [2:0] {
		ST_PREAMBLE,
		ST_START,
		ST_HDR,
		ST_WR_TA,
		ST_WR_DATA,
		ST_RD
	} pmrb_state_t;

endpackage

// File: pmrb_reg_cell.sv
// one management register with per-bit access behaviour set by masks
// assumes write and read strobes are single clock pulses from the port
`timescale 1ns/1ps
module pmrb_reg_cell #(
	parameter int unsigned     W           = 16,
	parameter logic [W-1:0]    RW_MASK     = '0,
	parameter logic [W-1:0]    DROP_MASK   = '0,
	parameter logic [W-1:0]    SS_MASK     = '0,
	parameter logic [W-1:0]    W1C_MASK    = '0,
	parameter logic [W-1:0]    ANYCLR_MASK = '0,
	parameter logic [W-1:0]    STICKY_MASK = '0,
	parameter logic [W-1:0]    LOWLAT_MASK = '0,
	parameter logic [W-1:0]    LIVE_MASK   = '0,
	parameter logic [W-1:0]    WO_MASK     = '0,
	parameter logic [W-1:0]    KEEP_MASK   = '0,
	parameter logic [W-1:0]    RST_VAL     = '0
) (
	// clock and resets
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         softRst,
	// access strobes
	input  wire logic         wrEn,
	input  wire logic [W-1:0] wrData,
	input  wire logic         rdEn,
	// hardware side
	input  wire logic [W-1:0] hwIn,
	input  wire logic [W-1:0] done,
	// register contents
	output logic      [W-1:0] value,
	output logic      [W-1:0] readData
);

	localparam logic [W-1:0] WR_SET = RW_MASK | DROP_MASK;
	localparam logic [W-1:0] HW_SET = STICKY_MASK | W1C_MASK | ANYCLR_MASK;

	generate
		if ((RW_MASK & (DROP_MASK | SS_MASK | W1C_MASK |
		     ANYCLR_MASK)) != '0 ||
		    (LOWLAT_MASK & LIVE_MASK) != '0 || W == 0) begin : gBadMasks
			$error("pmrb_reg_cell: overlapping access masks");
		end
	endgenerate

	logic [W-1:0] val_ff;
	logic [W-1:0] nxt_val;
	logic [W-1:0] doneStep;
	logic [W-1:0] wrStep;
	logic [W-1:0] rdStep;
	logic [W-1:0] setStep;
	logic [W-1:0] latchLow;
	logic [W-1:0] hwStep;
	logic [W-1:0] softStep;

	// self-clearing bits drop and self-setting bits return on done
	assign doneStep = (val_ff & ~(done & DROP_MASK)) |
	                  (done & SS_MASK);
	// bits outside every write mask keep their value on a write
	assign wrStep   = wrEn ? (((doneStep & ~RW_MASK) | (wrData & WR_SET))
	                          & ~(~wrData & SS_MASK)
	                          & ~(wrData & W1C_MASK)
	                          & ~ANYCLR_MASK)
	                       : doneStep;
	assign rdStep   = wrStep & ~({W{rdEn}} & STICKY_MASK);
	// a hardware event in the clearing cycle wins over the clear
	assign setStep  = rdStep | (hwIn & HW_SET);
	assign latchLow = hwIn & (val_ff | {W{rdEn}}) & LOWLAT_MASK;
	assign hwStep   = (setStep & ~(LOWLAT_MASK | LIVE_MASK)) |
	                  (hwIn & LIVE_MASK) | latchLow;
	assign softStep = (RST_VAL & ~KEEP_MASK) | (val_ff & KEEP_MASK);
	assign nxt_val  = softRst ? softStep : hwStep;

	always_ff @(posedge clock) begin
		if (rst) begin
			val_ff <= RST_VAL;
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign value    = val_ff;
	// write-only bits are hidden on reads
	assign readData = val_ff & ~WO_MASK;

endmodule

// File: pmrb_mgmt_bank.sv
// management register bank behind the serial management port
// assumes mdc and mdio are already synchronous to clock and mdc is
// well below clock/4; mdio is split into in, out and enable
`timescale 1ns/1ps
module pmrb_mgmt_bank
	import pmrb_pkg::*;
#(
	parameter int unsigned PRE_LEN       = PREAMBLE_LEN,
	parameter logic [15:0] CTRL_RST      = BC_RST_DEFAULT,
	// identifier defaults, values arbitrary
	parameter logic [15:0] ID_HIGH       = 16'h0a5a,
	parameter logic [15:0] ID_LOW        = 16'h5a50,
	parameter logic [15:0] SPMODES_RESET = SPMODE_RST
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// serial management port
	input  wire logic        mdc,
	input  wire logic        mdioIn,
	output logic             mdioOut,
	output logic             mdioOe,
	input  wire logic [4:0]  phyAddr,
	// line status
	input  wire logic        linkUp,
	input  wire logic        jabber,
	input  wire logic        remoteFault,
	input  wire logic        anComplete,
	input  wire logic [15:0] partnerAbility,
	input  wire logic [15:0] anExpansion,
	input  wire logic        symbolError,
	input  wire logic [15:0] intEvents,
	input  wire logic [1:0]  flagEvents,
	input  wire logic        anRestartDone,
	input  wire logic        selfSetDone,
	// control outputs
	output logic      [15:0] ctrlOut,
	output logic      [15:0] advertOut,
	output logic      [15:0] modeCtrlOut,
	output logic      [15:0] specialModesOut,
	output logic      [15:0] csIndOut,
	output logic      [15:0] intMaskOut,
	output logic      [15:0] specialCtrlOut
);

	localparam logic [5:0] PRE_CNT = 6'(PRE_LEN);

	generate
		if (PRE_LEN < 1 || PRE_LEN > 63) begin : gBadPreamble
			$error("pmrb_mgmt_bank: PRE_LEN must be 1..63");
		end
	endgenerate

	pmrb_state_t state_ff;
	pmrb_state_t nxt_state;
	logic [4:0]  cnt_ff;
	logic [4:0]  nxt_cnt;
	logic [5:0]  pre_ff;
	logic [5:0]  nxt_pre;
	logic [10:0] hdr_ff;
	logic [10:0] nxt_hdr;
	logic [15:0] sh_ff;
	logic [15:0] nxt_sh;
	logic [4:0]  regIdx_ff;
	logic [4:0]  nxt_regIdx;
	logic        mdcPrev_ff;
	logic        mdioOut_ff;
	logic        nxt_mdioOut;
	logic        mdioOe_ff;
	logic        nxt_mdioOe;
	logic [15:0] symCnt_ff;
	logic [15:0] nxt_symCnt;

	logic        mdcRise;
	logic        mdcFall;
	logic [11:0] hdrWord;
	logic        phyMatch;
	logic        opRead;
	logic        opWrite;
	logic        hdrDone;
	logic        rdCapture;
	logic        wrCommit;
	logic [15:0] wrData;
	logic [31:0] wrSel;
	logic [31:0] rdSel;
	logic [15:0] rdMux;
	logic        softRst;
	logic [15:0] bcDone;
	logic [15:0] bsHw;
	logic [15:0] bsRd;
	logic [15:0] id1Rd;
	logic [15:0] id2Rd;
	logic [15:0] scRd;
	logic [15:0] intSrcRd;

	// frame decode
	assign mdcRise   = mdc & ~mdcPrev_ff;
	assign mdcFall   = ~mdc & mdcPrev_ff;
	assign hdrWord   = {hdr_ff, mdioIn};
	assign phyMatch  = hdrWord[9:5] == phyAddr;
	assign opRead    = hdrWord[11:10] == OP_READ;
	assign opWrite   = hdrWord[11:10] == OP_WRITE;
	assign hdrDone   = mdcRise && state_ff == ST_HDR && cnt_ff == HDR_LAST;
	assign rdCapture = hdrDone & phyMatch & opRead;
	assign wrCommit  = mdcRise && state_ff == ST_WR_DATA &&
	                   cnt_ff == DATA_LAST;
	assign wrData    = {sh_ff[14:0], mdioIn};
	// unmapped indices select no register, so their writes vanish
	assign wrSel     = wrCommit ? (32'h00000001 << regIdx_ff) : 32'h0;
	assign rdSel     = rdCapture ? (32'h00000001 << hdrWord[4:0]) : 32'h0;

	// register select for reads
	assign rdMux =
		(hdrWord[4:0] == IDX_BASIC_CONTROL) ? ctrlOut :
		(hdrWord[4:0] == IDX_BASIC_STATUS)  ? bsRd :
		(hdrWord[4:0] == IDX_ID_HIGH)       ? id1Rd :
		(hdrWord[4:0] == IDX_ID_LOW)        ? id2Rd :
		(hdrWord[4:0] == IDX_AN_ADVERT)     ? advertOut :
		(hdrWord[4:0] == IDX_AN_PARTNER)    ? partnerAbility :
		(hdrWord[4:0] == IDX_AN_EXPANSION)  ? anExpansion :
		(hdrWord[4:0] == IDX_MODE_CTRL)     ? modeCtrlOut :
		(hdrWord[4:0] == IDX_SPECIAL_MODES) ? specialModesOut :
		(hdrWord[4:0] == IDX_SYMBOL_ERRORS) ? symCnt_ff :
		(hdrWord[4:0] == IDX_CS_INDICATION) ? csIndOut :
		(hdrWord[4:0] == IDX_INT_SOURCE)    ? intSrcRd :
		(hdrWord[4:0] == IDX_INT_MASK)      ? intMaskOut :
		(hdrWord[4:0] == IDX_SPECIAL_CTRL)  ? scRd :
		16'h0000;

	// soft reset lasts one cycle and clears its own bit via the defaults
	assign softRst = ctrlOut[15];
	assign bcDone  = anRestartDone ? BC_RESTART_AN : 16'h0000;
	assign bsHw    = {10'h000, anComplete, remoteFault, 1'b0, linkUp,
	                  jabber, 1'b0};

	// serial frame engine
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_pre     = pre_ff;
		nxt_hdr     = hdr_ff;
		nxt_sh      = sh_ff;
		nxt_regIdx  = regIdx_ff;
		nxt_mdioOut = mdioOut_ff;
		nxt_mdioOe  = mdioOe_ff;
		case (state_ff)
			ST_PREAMBLE: if (mdcRise) begin
				if (mdioIn) begin
					nxt_pre = (pre_ff == PRE_CNT) ? pre_ff : 6'(pre_ff + 6'h01);
				end else if (pre_ff == PRE_CNT) begin
					nxt_state = ST_START;
					nxt_pre   = 6'h00;
				end else begin
					nxt_pre = 6'h00;
				end
			end
			ST_START: if (mdcRise) begin
				nxt_state = mdioIn ? ST_HDR : ST_PREAMBLE;
				nxt_cnt   = 5'h00;
			end
			ST_HDR: if (mdcRise) begin
				nxt_hdr = hdrWord[10:0];
				nxt_cnt = 5'(cnt_ff + 5'h01);
				if (cnt_ff == HDR_LAST) begin
					nxt_cnt    = 5'h00;
					nxt_regIdx = hdrWord[4:0];
					nxt_sh     = rdMux;
					// foreign address or bad opcode: wait for a new preamble
					nxt_state  = !phyMatch ? ST_PREAMBLE :
					             opRead ? ST_RD :
					             opWrite ? ST_WR_TA : ST_PREAMBLE;
				end
			end
			ST_WR_TA: if (mdcRise) begin
				nxt_cnt = 5'(cnt_ff + 5'h01);
				if (cnt_ff == TA_LAST) begin
					nxt_state = ST_WR_DATA;
					nxt_cnt   = 5'h00;
				end
			end
			ST_WR_DATA: if (mdcRise) begin
				nxt_sh  = wrData;
				nxt_cnt = 5'(cnt_ff + 5'h01);
				if (cnt_ff == DATA_LAST) begin
					nxt_state = ST_PREAMBLE;
					nxt_cnt   = 5'h00;
				end
			end
			ST_RD: if (mdcFall) begin
				// drive on falling mdc so data is stable at the rising edge
				nxt_cnt = 5'(cnt_ff + 5'h01);
				if (cnt_ff == RD_TA_FALL) begin
					nxt_mdioOe  = 1'b1;
					nxt_mdioOut = 1'b0;
				end else if (cnt_ff >= RD_DATA_FALL && cnt_ff < RD_REL_FALL) begin
					nxt_mdioOut = sh_ff[15];
					nxt_sh      = {sh_ff[14:0], 1'b0};
				end else if (cnt_ff == RD_REL_FALL) begin
					nxt_mdioOe  = 1'b0;
					nxt_mdioOut = 1'b0;
					nxt_state   = ST_PREAMBLE;
					nxt_cnt     = 5'h00;
				end
			end
			default: begin
				nxt_state  = ST_PREAMBLE;
				nxt_mdioOe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff   <= ST_PREAMBLE;
			cnt_ff     <= 5'h00;
			pre_ff     <= 6'h00;
			hdr_ff     <= 11'h000;
			sh_ff      <= 16'h0000;
			regIdx_ff  <= 5'h00;
			mdcPrev_ff <= 1'b0;
			mdioOut_ff <= 1'b0;
			mdioOe_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			pre_ff     <= nxt_pre;
			hdr_ff     <= nxt_hdr;
			sh_ff      <= nxt_sh;
			regIdx_ff  <= nxt_regIdx;
			mdcPrev_ff <= mdc;
			mdioOut_ff <= nxt_mdioOut;
			mdioOe_ff  <= nxt_mdioOe;
		end
	end

	assign mdioOut = mdioOut_ff;
	assign mdioOe  = mdioOe_ff;

	// symbol error count saturates rather than wrapping to zero
	assign nxt_symCnt =
		rdSel[IDX_SYMBOL_ERRORS] ? {15'h0000, symbolError} :
		(symbolError && symCnt_ff != 16'hffff) ? 16'(symCnt_ff + 16'h0001) :
		symCnt_ff;

	always_ff @(posedge clock) begin
		if (rst || softRst) begin
			symCnt_ff <= 16'h0000;
		end else begin
			symCnt_ff <= nxt_symCnt;
		end
	end

	// register cells
	pmrb_reg_cell #(.RW_MASK(BC_RW), .DROP_MASK(BC_DROP), .RST_VAL(CTRL_RST))
	uBasicCtrl (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_BASIC_CONTROL]), .wrData(wrData),
		.rdEn(rdSel[IDX_BASIC_CONTROL]), .hwIn(16'h0000), .done(bcDone),
		.value(ctrlOut), .readData());

	pmrb_reg_cell #(.STICKY_MASK(BS_STICKY), .LOWLAT_MASK(BS_LOWLAT),
		.LIVE_MASK(BS_LIVE), .RST_VAL(BS_RST))
	uBasicStatus (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_BASIC_STATUS]), .wrData(wrData),
		.rdEn(rdSel[IDX_BASIC_STATUS]), .hwIn(bsHw), .done(16'h0000),
		.value(), .readData(bsRd));

	pmrb_reg_cell #(.RW_MASK(ALL_BITS), .RST_VAL(ID_HIGH))
	uIdHigh (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_ID_HIGH]), .wrData(wrData),
		.rdEn(rdSel[IDX_ID_HIGH]), .hwIn(16'h0000), .done(16'h0000),
		.value(), .readData(id1Rd));

	pmrb_reg_cell #(.RW_MASK(ALL_BITS), .RST_VAL(ID_LOW))
	uIdLow (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_ID_LOW]), .wrData(wrData),
		.rdEn(rdSel[IDX_ID_LOW]), .hwIn(16'h0000), .done(16'h0000),
		.value(), .readData(id2Rd));

	pmrb_reg_cell #(.RW_MASK(ALL_BITS), .RST_VAL(ADVERT_RST))
	uAdvert (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_AN_ADVERT]), .wrData(wrData),
		.rdEn(rdSel[IDX_AN_ADVERT]), .hwIn(16'h0000), .done(16'h0000),
		.value(advertOut), .readData());

	pmrb_reg_cell #(.RW_MASK(ALL_BITS))
	uModeCtrl (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_MODE_CTRL]), .wrData(wrData),
		.rdEn(rdSel[IDX_MODE_CTRL]), .hwIn(16'h0000), .done(16'h0000),
		.value(modeCtrlOut), .readData());

	// special modes carry configuration that a soft reset must not lose
	pmrb_reg_cell #(.RW_MASK(ALL_BITS), .KEEP_MASK(ALL_BITS),
		.RST_VAL(SPMODES_RESET))
	uSpecialModes (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_SPECIAL_MODES]), .wrData(wrData),
		.rdEn(rdSel[IDX_SPECIAL_MODES]), .hwIn(16'h0000), .done(16'h0000),
		.value(specialModesOut), .readData());

	pmrb_reg_cell #(.RW_MASK(CSI_RW), .W1C_MASK(CSI_W1C))
	uCsInd (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_CS_INDICATION]), .wrData(wrData),
		.rdEn(rdSel[IDX_CS_INDICATION]), .hwIn({15'h0000, flagEvents[0]}),
		.done(16'h0000), .value(csIndOut), .readData());

	pmrb_reg_cell #(.STICKY_MASK(ALL_BITS))
	uIntSource (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_INT_SOURCE]), .wrData(wrData),
		.rdEn(rdSel[IDX_INT_SOURCE]), .hwIn(intEvents), .done(16'h0000),
		.value(), .readData(intSrcRd));

	pmrb_reg_cell #(.RW_MASK(ALL_BITS))
	uIntMask (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_INT_MASK]), .wrData(wrData),
		.rdEn(rdSel[IDX_INT_MASK]), .hwIn(16'h0000), .done(16'h0000),
		.value(intMaskOut), .readData());

	pmrb_reg_cell #(.RW_MASK(SPC_RW), .ANYCLR_MASK(SPC_ANYCLR),
		.SS_MASK(SPC_SS), .WO_MASK(SPC_WO), .RST_VAL(SPC_RST))
	uSpecialCtrl (.clock(clock), .rst(rst), .softRst(softRst),
		.wrEn(wrSel[IDX_SPECIAL_CTRL]), .wrData(wrData),
		.rdEn(rdSel[IDX_SPECIAL_CTRL]), .hwIn({flagEvents[1], 15'h0000}),
		.done(selfSetDone ? SPC_SS : 16'h0000), .value(specialCtrlOut),
		.readData(scRd));

endmodule

// File: pmrb_assertions.sv
// checker of the management register bank, bound to its top module
// assumes mdc runs well below clock/4, so a read drives over many clocks
`timescale 1ns/1ps
module pmrb_assertions #(
	parameter logic [15:0] CTRL_RST = 16'h3100
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        mdc,
	input wire logic        mdioOut,
	input wire logic        mdioOe,
	input wire logic [1:0]  flagEvents,
	input wire logic        anRestartDone,
	input wire logic        selfSetDone,
	input wire logic [15:0] ctrlOut,
	input wire logic [15:0] advertOut,
	input wire logic [15:0] specialModesOut,
	input wire logic [15:0] csIndOut,
	input wire logic [15:0] intMaskOut,
	input wire logic [15:0] specialCtrlOut
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_RST_VALUES: assert property (disable iff (1'b0)
		rst |=> !mdioOe && ctrlOut == CTRL_RST &&
		specialCtrlOut == 16'h4000)
		else $error("reset values wrong");
	AST_SOFT_RESET: assert property (
		ctrlOut[15] |=> ctrlOut == CTRL_RST && advertOut == 16'h0000 &&
		intMaskOut == 16'h0000 && $stable(specialModesOut))
		else $error("software reset did not restore or keep");
	AST_DROP_HOLD: assert property (
		ctrlOut[9] && !anRestartDone && !ctrlOut[15] |=> ctrlOut[9])
		else $error("self-clearing bit dropped early");
	// a write committed on an mdc rise in the done cycle wins, so skip it
	AST_DROP_DONE: assert property (
		anRestartDone && !ctrlOut[15] && !$rose(mdc) |=> !ctrlOut[9])
		else $error("self-clearing bit not cleared");
	AST_SELF_SET: assert property (
		selfSetDone && !$rose(mdc) |=> specialCtrlOut[14])
		else $error("self-setting bit not set");
	AST_W1C_SET: assert property (
		flagEvents[0] && !ctrlOut[15] |=> csIndOut[0])
		else $error("event bit not set");
	AST_WR_TIMING: assert property (
		!$stable(intMaskOut) && !$past(rst) && !$past(ctrlOut[15]) |->
		$past(mdc) && !$past(mdc, 2))
		else $error("register changed off a write commit");
	AST_TA_LOW: assert property ($rose(mdioOe) |-> !mdioOut)
		else $error("turnaround not driven low");
	AST_OE_SPAN: assert property (
		$rose(mdioOe) |-> mdioOe[*8] ##[1:1000] !mdioOe)
		else $error("read drive span wrong");
	AST_OUT_ON_FALL: assert property (
		!$stable(mdioOut) |-> !$past(mdc) && $past(mdc, 2))
		else $error("data changed off an mdc fall");

	cover property (ctrlOut[15]);
	cover property ($rose(mdioOe));
	cover property (selfSetDone);
	cover property (flagEvents[1]);
endmodule

// File: pmrb_station.sv
// station management controller model driving the serial management port
// assumes the bench resolves the shared wire, released wire pulled high
`timescale 1ns/1ps
module pmrb_station
	import pmrb_pkg::*;
(
	// clock
	input  wire logic clock,
	// management wire
	input  wire logic mdioWire,
	output logic      mdc,
	output logic      mdoBit,
	output logic      mdoEn
);
	initial begin
		mdc = 1'b0;
		mdoBit = 1'b1;
		mdoEn = 1'b0;
	end

	// one mdc period of eight clocks; data moves only while mdc is low
	task automatic slot(input logic b, input logic en, output logic s);
		@(negedge clock);
		mdc = 1'b0;
		mdoBit = b;
		mdoEn = en;
		repeat (4) @(negedge clock);
		mdc = 1'b1;
		s = mdioWire;
		repeat (3) @(negedge clock);
	endtask

	// full frame with preamble, one word msb first; mdc idles low after
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		logic        s;
		f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			slot(f[i], op != OP_READ || i > 17, s);
			if (i < 16)
				rd[i] = s;
		end
		@(negedge clock);
		mdc = 1'b0;
		mdoEn = 1'b0;
		repeat (8) @(negedge clock);
	endtask
endmodule

// File: pmrb_mgmt_bank_bench.sv
// self-checking bench of the management register bank
// assumes pmrb_station as the far side and the checker bound below
`timescale 1ns/1ps
module pmrb_mgmt_bank_bench;
	import pmrb_pkg::*;
	logic clock, rst, mdc, mdoBit, mdoEn, mdioOut, mdioOe, linkUp, jabber;
	logic remoteFault, anComplete, symbolError, anRestartDone, selfSetDone;
	logic [1:0] flagEvents;
	logic [15:0] partnerAbility, anExpansion, intEvents, ctrlOut, advertOut;
	logic [15:0] modeCtrlOut, specialModesOut, csIndOut, intMaskOut;
	logic [15:0] specialCtrlOut, rv;
	logic [4:0] rwIdx [6] = '{5'h02, 5'h03, 5'h04, 5'h11, 5'h12, 5'h1e};
	wire logic mdioWire = mdioOe ? mdioOut : (mdoEn ? mdoBit : 1'b1);
	int failures = 0;
	int checksDone = 0;

	pmrb_mgmt_bank dut (.clock(clock), .rst(rst), .mdc(mdc),
		.mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe),
		.phyAddr(5'h01), .linkUp(linkUp), .jabber(jabber),
		.remoteFault(remoteFault), .anComplete(anComplete),
		.partnerAbility(partnerAbility), .anExpansion(anExpansion),
		.symbolError(symbolError), .intEvents(intEvents),
		.flagEvents(flagEvents), .anRestartDone(anRestartDone),
		.selfSetDone(selfSetDone), .ctrlOut(ctrlOut), .advertOut(advertOut),
		.modeCtrlOut(modeCtrlOut), .specialModesOut(specialModesOut),
		.csIndOut(csIndOut), .intMaskOut(intMaskOut),
		.specialCtrlOut(specialCtrlOut));
	pmrb_station sta (.clock(clock), .mdioWire(mdioWire), .mdc(mdc),
		.mdoBit(mdoBit), .mdoEn(mdoEn));

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	task automatic wrap_up();
		if (failures == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		sta.xfer(OP_WRITE, 5'h01, ra, d, rv);
	endtask
	// reads and compares the unmasked bits only
	task automatic rchk(input logic [4:0] ra, input logic [15:0] m,
		input logic [15:0] e);
		sta.xfer(OP_READ, 5'h01, ra, 16'h0000, rv);
		chk(rv & m, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic hwReset();
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
	endtask

	initial begin
		{linkUp, jabber, remoteFault, anComplete, symbolError} = '0;
		{anRestartDone, selfSetDone, flagEvents, intEvents} = '0;
		partnerAbility = 16'h1234;
		anExpansion = 16'h0041;
		hwReset();
		chk(ctrlOut, 16'h3100);
		chk(specialCtrlOut, 16'h4000);
		rchk(5'h02, 16'hffff, 16'h0a5a);
		rchk(5'h01, 16'hf83f, 16'h7809);
		linkUp = 1'b1;
		jabber = 1'b1;
		remoteFault = 1'b1;
		anComplete = 1'b1;
		tick(1);
		jabber = 1'b0;
		tick(2);
		rchk(5'h01, 16'hf83f, 16'h783b);
		rchk(5'h01, 16'hf83f, 16'h783d);
		remoteFault = 1'b0;
		linkUp = 1'b0;
		tick(2);
		linkUp = 1'b1;
		rchk(5'h01, 16'hf83f, 16'h7839);
		rchk(5'h01, 16'hf83f, 16'h782d);
		foreach (rwIdx[k]) begin
			wr(rwIdx[k], 16'hc300 | 16'(rwIdx[k]));
			rchk(rwIdx[k], 16'hffff, 16'hc300 | 16'(rwIdx[k]));
		end
		chk(advertOut, 16'hc304);
		chk(modeCtrlOut, 16'hc311);
		chk(intMaskOut, 16'hc31e);
		wr(5'h07, 16'hffff);
		wr(5'h14, 16'hffff);
		chk(modeCtrlOut, 16'hc311);
		rchk(5'h07, 16'hffff, 16'h0000);
		rchk(5'h1c, 16'hffff, 16'h0000);
		wr(5'h05, 16'hffff);
		wr(5'h06, 16'hffff);
		rchk(5'h05, 16'hffff, 16'h1234);
		rchk(5'h06, 16'hffff, 16'h0041);
		sta.xfer(OP_WRITE, 5'h02, 5'h04, 16'h0f0f, rv);
		sta.xfer(2'b00, 5'h01, 5'h04, 16'h0f0f, rv);
		sta.xfer(2'b11, 5'h01, 5'h04, 16'h0f0f, rv);
		chk(advertOut, 16'hc304);
		sta.xfer(OP_READ, 5'h02, 5'h04, 16'h0000, rv);
		chk(rv, 16'hffff);
		repeat (3) begin
			tick(1);
			symbolError = 1'b1;
			tick(1);
			symbolError = 1'b0;
		end
		rchk(5'h1a, 16'hffff, 16'h0003);
		rchk(5'h1a, 16'hffff, 16'h0000);
		wr(5'h1a, 16'h0055);
		rchk(5'h1a, 16'hffff, 16'h0000);
		intEvents = 16'h0a05;
		tick(1);
		intEvents = 16'h0000;
		rchk(5'h1d, 16'hffff, 16'h0a05);
		rchk(5'h1d, 16'hffff, 16'h0000);
		flagEvents = 2'b11;
		tick(1);
		flagEvents = 2'b00;
		tick(2);
		chk(csIndOut, 16'h0001);
		wr(5'h1b, 16'hab00);
		chk(csIndOut, 16'hab01);
		wr(5'h1b, 16'hab01);
		chk(csIndOut, 16'hab00);
		rchk(5'h1f, 16'hdfff, 16'hc000);
		wr(5'h1f, 16'h4012);
		chk(specialCtrlOut, 16'h4012);
		wr(5'h1f, 16'h2000);
		chk(specialCtrlOut, 16'h2000);
		rchk(5'h1f, 16'hdfff, 16'h0000);
		// writing one to the cleared self-setting bit must not set it
		wr(5'h1f, 16'h6000);
		chk(specialCtrlOut, 16'h2000);
		selfSetDone = 1'b1;
		tick(1);
		selfSetDone = 1'b0;
		tick(2);
		chk(specialCtrlOut, 16'h6000);
		wr(5'h00, 16'h3300);
		wr(5'h00, 16'h3100);
		chk(ctrlOut, 16'h3300);
		anRestartDone = 1'b1;
		tick(1);
		anRestartDone = 1'b0;
		tick(2);
		rchk(5'h00, 16'hffff, 16'h3100);
		wr(5'h00, 16'h8000);
		tick(3);
		chk(ctrlOut, 16'h3100);
		chk(advertOut, 16'h0000);
		chk(specialModesOut, 16'hc312);
		hwReset();
		chk(specialModesOut, 16'h0000);
		wrap_up();
	end

	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		wrap_up();
	end
endmodule

bind pmrb_mgmt_bank pmrb_assertions #(.CTRL_RST(CTRL_RST)) chk_i (
	.clock(clock), .rst(rst), .mdc(mdc), .mdioOut(mdioOut),
	.mdioOe(mdioOe), .flagEvents(flagEvents),
	.anRestartDone(anRestartDone), .selfSetDone(selfSetDone),
	.ctrlOut(ctrlOut), .advertOut(advertOut),
	.specialModesOut(specialModesOut), .csIndOut(csIndOut),
	.intMaskOut(intMaskOut), .specialCtrlOut(specialCtrlOut));
